//--- common/suspend_wake_pkg.sv
// Constants, types and register map of the suspend and wake-up control block.
// Assumes a 100 MHz free-running core clock; gated clocks are driven by enables out of this block.
//
// Notes on behaviour
// RULE_01: Overload source select bit 10 resets to 0, selecting the external detector.
// RULE_02: Writing sleep state into the mode field (read 01H, write 81H) suspends.
// RULE_03: While suspended, internal clock, PLL, oscillator stop and regulator powers down.
// RULE_04: Entering the bus sleep state drives the suspend indicator high.
// RULE_05: Suspend indicator falls only when mode field becomes bus reset or running.
// RULE_06: Keep-running bit 11 at 0 stops the clock 1.3 ms after sleep entry.
// RULE_07: Sleep is left on wake pin pulse, chip select access, or bus resume.
// RULE_08: Wake pin high in sleep restarts clock and sets clock-up bit 6 at 24H.
// RULE_09: Clock is running within 160 us of wake pin going high in sleep.
// RULE_10: Clock stays on while wake pin stays high; driver may then select running.
// RULE_11: Wake pin low more than 1.14 ms after a wake stops the clock again.
// RULE_12: A chip select assertion during sleep acts as a software wake.
// RULE_13: Bus resume in sleep moves mode to resume and sets the resume-seen flag.
// RULE_14: Driver enables interrupt bits for the wake source before entering sleep.
// RULE_15: Driver preserves reserved bits by read-modify-write or a shadow copy.
// RULE_16: Driver writes zeros into reserved fields on set or clear writes.
// RULE_17: Operational registers are 32 bits, read command equals byte offset over four.
// RULE_18: Write command equals read command with bit 7 set.
package suspend_wake_pkg;

  // ----------------------------------------
  // Register commands (read form)
  // ----------------------------------------
  localparam logic [6:0] REG_REVISION = 7'h00;
  localparam logic [6:0] REG_MODE = 7'h01;
  localparam logic [6:0] REG_CMD_STATUS = 7'h02;
  localparam logic [6:0] REG_EVENT_STATUS = 7'h03;
  localparam logic [6:0] REG_ENABLE_SET = 7'h04;
  localparam logic [6:0] REG_ENABLE_CLEAR = 7'h05;
  localparam logic [6:0] REG_FRAME_INTERVAL = 7'h0d;
  localparam logic [6:0] REG_FRAME_LEFT = 7'h0e;
  localparam logic [6:0] REG_FRAME_INDEX = 7'h0f;
  localparam logic [6:0] REG_SLOW_THRESHOLD = 7'h11;
  localparam logic [6:0] REG_HW_SETUP = 7'h20;
  localparam logic [6:0] REG_PROC_EVENT = 7'h24;
  localparam int WRITE_FLAG_BIT = 7;
  localparam int WIDE_REG_LIMIT = 8'h20; // Commands below this are 32-bit

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int MODE_FIELD_LO = 6;
  localparam int OVERLOAD_SELECT_BIT = 10;
  localparam int KEEP_CLOCK_BIT = 11;
  localparam int CLOCK_UP_BIT = 6;
  localparam int BUS_WAKE_SEEN_BIT = 3;
  localparam logic [31:0] REVISION_VALUE = 32'h0000_0010;
  localparam logic [31:0] WIDE_RESET = 32'h0000_0000;
  localparam logic [15:0] NARROW_RESET = 16'h0000;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SLEEP_STOP_NS = 1_300_000;
  localparam int WAKE_UP_NS = 160_000;
  localparam int WAKE_LOW_NS = 1_140_000;
  localparam int STOP_CYCLES = (SLEEP_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_UP_CYCLES = WAKE_UP_NS / CLK_PERIOD_NS;
  localparam int WAKE_LOW_CYCLES = (WAKE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DWELL_W = 18;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    bus_reset_state = 2'h0,
    bus_wake_state = 2'h1,
    bus_running_state = 2'h2,
    bus_sleep_state = 2'h3
  } host_mode_e;

  typedef enum logic [2:0] {
    clk_running = 3'h0,
    sleep_settle = 3'h1,
    clk_stopped = 3'h3,
    clk_starting = 3'h2,
    wake_hold = 3'h6
  } power_e;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic cmd_sel;
    logic [15:0] data;
  } host_bus_s;

endpackage

//--- logic/host_suspend_wake_control.sv
// Suspend/wake control with the command-style register port of the host controller.
// Assumes asynchronous host pins held stable for several core clocks per strobe.
`timescale 1ns/10ps
`default_nettype none

module host_suspend_wake_control
  import suspend_wake_pkg::*;
#(
  parameter int STOP_COUNT = STOP_CYCLES,
  parameter int WAKE_UP_COUNT = WAKE_UP_CYCLES,
  parameter int WAKE_LOW_COUNT = WAKE_LOW_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Processor bus pins
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic cmd_sel,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe_n,
  // Wake sources
  input wire logic wake_request_in,
  input wire logic bus_resume_in,
  // Power and status outputs
  output logic suspend_out,
  output logic int_clock_run,
  output logic pll_osc_on,
  output logic regulator_power_down,
  output logic internal_overload_sense_select
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  host_bus_s bus_meta;
  host_bus_s bus_sync;
  host_bus_s bus_prev;
  logic [1:0] wake_meta;
  logic [1:0] wake_sync;

  // Two flops on every pin, then one history stage on the bus pins only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_meta <= '1;
      bus_sync <= '1;
      bus_prev <= '1;
      wake_meta <= '0;
      wake_sync <= '0;
    end else begin
      bus_meta <= '{cs_n: cs_n, rd_n: rd_n, wr_n: wr_n, cmd_sel: cmd_sel, data: data_in};
      bus_sync <= bus_meta;
      bus_prev <= bus_sync;
      wake_meta <= {bus_resume_in, wake_request_in};
      wake_sync <= wake_meta;
    end
  end

  // ----------------------------------------
  // Strobe decode
  // ----------------------------------------
  wire logic wake_pin = wake_sync[0];
  wire logic resume_pin = wake_sync[1];
  wire logic selected = !bus_sync.cs_n;
  wire logic wr_done = selected && bus_sync.wr_n && !bus_prev.wr_n;
  wire logic rd_done = selected && bus_sync.rd_n && !bus_prev.rd_n;
  wire logic rd_active = selected && !bus_sync.rd_n && !bus_sync.cmd_sel;
  wire logic cmd_write = wr_done && bus_sync.cmd_sel;
  wire logic data_write = wr_done && !bus_sync.cmd_sel;
  wire logic data_read = rd_done && !bus_sync.cmd_sel;

  // ----------------------------------------
  // Command and word tracking
  // ----------------------------------------
  logic [7:0] command;
  logic high_word;
  logic [15:0] low_word;

  // RULE_17: 32-bit registers take two words
  wire logic wide_reg = command[6:0] < 7'(WIDE_REG_LIMIT);
  // RULE_18: bit 7 marks a write command
  wire logic is_write_cmd = command[WRITE_FLAG_BIT];
  wire logic [6:0] reg_sel = command[6:0];
  wire logic commit = data_write && is_write_cmd && (!wide_reg || high_word);
  wire logic [31:0] wdata = wide_reg ? {bus_sync.data, low_word} : {16'h0000, bus_sync.data};

  // Command latch and low/high word sequencing
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      command <= 8'h00;
      high_word <= 1'b0;
      low_word <= 16'h0000;
    end else if (cmd_write) begin
      command <= bus_sync.data[7:0];
      high_word <= 1'b0;
    end else if ((data_write || data_read) && wide_reg) begin
      high_word <= !high_word;
      if (data_write && !high_word) begin
        low_word <= bus_sync.data;
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0] mode_ctrl;
  logic [31:0] cmd_status;
  logic [31:0] event_status;
  logic [31:0] event_enable;
  logic [31:0] frame_interval;
  logic [31:0] slow_threshold;
  logic [15:0] hardware_setup;
  logic [15:0] proc_event;
  power_e state;
  power_e next_state;
  logic [DWELL_W-1:0] dwell;

  wire logic [1:0] mode_field = mode_ctrl[MODE_FIELD_LO+1:MODE_FIELD_LO];
  wire logic in_sleep = mode_field == bus_sleep_state;
  wire logic wr_mode = commit && reg_sel == REG_MODE;
  // RULE_13: resume seen while asleep
  wire logic bus_wake_hit = in_sleep && resume_pin;
  wire logic clock_up_hit = state == clk_starting && 32'(dwell) >= WAKE_UP_COUNT - 1;

  // Mode register; a write loses to a same-cycle bus resume
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ctrl <= WIDE_RESET;
    end else if (bus_wake_hit) begin
      mode_ctrl[MODE_FIELD_LO+1:MODE_FIELD_LO] <= bus_wake_state;
    end else if (wr_mode) begin
      // RULE_02: driver selects the mode
      mode_ctrl <= wdata;
    end
  end

  // Plain read/write registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_status <= WIDE_RESET;
      frame_interval <= WIDE_RESET;
      slow_threshold <= WIDE_RESET;
      // RULE_01: external overload detector selected after reset
      hardware_setup <= NARROW_RESET;
    end else if (commit) begin
      case (reg_sel)
        REG_CMD_STATUS: cmd_status <= wdata;
        REG_FRAME_INTERVAL: frame_interval <= wdata;
        REG_SLOW_THRESHOLD: slow_threshold <= wdata;
        REG_HW_SETUP: hardware_setup <= wdata[15:0];
        default: ;
      endcase
    end
  end

  // Enable set/clear pair
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      event_enable <= WIDE_RESET;
    end else if (commit && reg_sel == REG_ENABLE_SET) begin
      event_enable <= event_enable | wdata;
    end else if (commit && reg_sel == REG_ENABLE_CLEAR) begin
      event_enable <= event_enable & ~wdata;
    end
  end

  // Sticky event flags: write one clears, hardware set wins
  wire logic [31:0] ev_clr = (commit && reg_sel == REG_EVENT_STATUS) ? wdata : WIDE_RESET;
  wire logic [15:0] pe_clr = (commit && reg_sel == REG_PROC_EVENT) ? wdata[15:0] : NARROW_RESET;
  wire logic [31:0] ev_set = 32'(bus_wake_hit) << BUS_WAKE_SEEN_BIT;
  wire logic [15:0] pe_set = 16'(clock_up_hit) << CLOCK_UP_BIT;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      event_status <= WIDE_RESET;
      proc_event <= NARROW_RESET;
    end else begin
      // RULE_13: resume-seen flag
      event_status <= (event_status & ~ev_clr) | ev_set;
      // RULE_08: clock-up flag
      proc_event <= (proc_event & ~pe_clr) | pe_set;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [31:0] rdata;

  // Read multiplexer; unmapped commands read zero
  always_comb begin
    case (reg_sel)
      REG_REVISION: rdata = REVISION_VALUE;
      REG_MODE: rdata = mode_ctrl;
      REG_CMD_STATUS: rdata = cmd_status;
      REG_EVENT_STATUS: rdata = event_status;
      REG_ENABLE_SET: rdata = event_enable;
      REG_ENABLE_CLEAR: rdata = event_enable;
      REG_FRAME_INTERVAL: rdata = frame_interval;
      REG_SLOW_THRESHOLD: rdata = slow_threshold;
      REG_HW_SETUP: rdata = {16'h0000, hardware_setup};
      REG_PROC_EVENT: rdata = {16'h0000, proc_event};
      default: rdata = WIDE_RESET;
    endcase
  end

  // Output word and driver enable
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= 16'h0000;
      data_oe_n <= 1'b1;
    end else begin
      data_out <= (wide_reg && high_word) ? rdata[31:16] : rdata[15:0];
      data_oe_n <= !rd_active;
    end
  end

  // ----------------------------------------
  // Power state machine
  // ----------------------------------------
  // RULE_12: chip select counts as a wake
  wire logic any_wake = wake_pin || selected || resume_pin;
  wire logic keep_clock = hardware_setup[KEEP_CLOCK_BIT];

  // Next power state
  always_comb begin
    next_state = state;
    case (state)
      clk_running: begin
        if (in_sleep) begin
          next_state = sleep_settle;
        end
      end
      sleep_settle: begin
        // RULE_06: stop after settle unless kept running
        if (!in_sleep) begin
          next_state = clk_running;
        end else if (!keep_clock && 32'(dwell) >= STOP_COUNT - 1) begin
          next_state = clk_stopped;
        end
      end
      clk_stopped: begin
        // RULE_07: any wake source restarts
        if (!in_sleep || any_wake) begin
          next_state = clk_starting;
        end
      end
      clk_starting: begin
        // RULE_09: clock up within bound
        if (clock_up_hit) begin
          next_state = in_sleep ? wake_hold : clk_running;
        end
      end
      wake_hold: begin
        // RULE_10: running while wake is held
        if (!in_sleep) begin
          next_state = clk_running;
        end else if (!keep_clock && 32'(dwell) >= WAKE_LOW_COUNT) begin
          // RULE_11: wake low too long
          next_state = clk_stopped;
        end
      end
      default: next_state = clk_running;
    endcase
  end

  // Dwell counter restarts on each state change and on wake activity in hold
  wire logic dwell_clear = next_state != state || (state == wake_hold && any_wake);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= clk_running;
      dwell <= '0;
    end else begin
      state <= next_state;
      dwell <= dwell_clear ? '0 : dwell + 1'b1;
    end
  end

  // ----------------------------------------
  // Suspend indicator
  // ----------------------------------------
  logic suspend_flag;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      suspend_flag <= 1'b0;
    end else if (in_sleep) begin
      // RULE_04: indicator high on sleep
      suspend_flag <= 1'b1;
    end else if (mode_field == bus_reset_state || mode_field == bus_running_state) begin
      // RULE_05: only reset or running clears
      suspend_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // RULE_03: clock, PLL, oscillator, regulator
  assign int_clock_run = state != clk_stopped && state != clk_starting;
  assign pll_osc_on = state != clk_stopped;
  assign regulator_power_down = state == clk_stopped;
  assign suspend_out = suspend_flag;
  // RULE_01: source select follows bit 10
  assign internal_overload_sense_select = hardware_setup[OVERLOAD_SELECT_BIT];

endmodule

`default_nettype wire

//--- tb/host_suspend_wake_control_monitor.sv
// Checker for the suspend and wake-up block, bound to its top ports.
// Assumes the bind hands on the scaled wake counts of the instance.
`timescale 1ns/10ps
`default_nettype none
module host_suspend_wake_control_monitor #(
  parameter int WAKE_UP_COUNT = 8,
  parameter int WAKE_LOW_COUNT = 12
) (
  // Clock, reset and watched pins
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic wake_request_in,
  input wire logic data_oe_n,
  input wire logic suspend_out,
  input wire logic int_clock_run,
  input wire logic pll_osc_on,
  input wire logic regulator_power_down,
  input wire logic internal_overload_sense_select
);
  localparam int WAKE_LIMIT = WAKE_UP_COUNT + 8;
  logic [7:0] since_wr;
  logic [7:0] wake_low;
  default clocking mon_cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Cycles since a write strobe and since wake
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      since_wr <= 8'hff;
      wake_low <= 8'h00;
    end else begin
      since_wr <= !wr_n ? 8'h00 : since_wr + {7'h00, since_wr != 8'hff};
      wake_low <= wake_request_in ? 8'h00 : wake_low + {7'h00, wake_low != 8'hff};
    end
  end
  reset_values_a: assert property ($rose(rst_n) |-> !internal_overload_sense_select && !suspend_out
    && int_clock_run && pll_osc_on && !regulator_power_down && data_oe_n)
    else $error("outputs wrong after reset release");
  read_release_a: assert property ((rd_n || cs_n) [*5] |-> data_oe_n)
    else $error("data driven without a read");
  stop_power_a: assert property (!pll_osc_on |-> !int_clock_run && regulator_power_down && suspend_out)
    else $error("oscillator off without full power down");
  clock_stop_a: assert property ($fell(int_clock_run) |-> suspend_out)
    else $error("clock stopped outside sleep");
  wake_start_a: assert property ($rose(wake_request_in) && !pll_osc_on |-> ##[1:WAKE_LIMIT] int_clock_run)
    else $error("clock late after wake pin");
  wake_run_a: assert property (wake_request_in [*3] ##0 int_clock_run |=> int_clock_run)
    else $error("clock stopped while wake pin high");
  wake_low_a: assert property ($fell(int_clock_run) |-> wake_low >= WAKE_LOW_COUNT)
    else $error("clock stopped too soon after wake pin low");
  suspend_rise_a: assert property ($rose(suspend_out) |-> since_wr < 12)
    else $error("suspend indicator rose without a mode write");
  suspend_fall_a: assert property ($fell(suspend_out) |-> since_wr < 12)
    else $error("suspend indicator fell without a mode write");
endmodule
`default_nettype wire

//--- tb/host_cpu_model.sv
// Host processor model driving the command-style register pins.
// Assumes the free-running core clock; strobes last five clocks.
`timescale 1ns/10ps
`default_nettype none
module host_cpu_model
  import suspend_wake_pkg::*;
(
  // Clock and read-back
  input wire logic core_clk,
  input wire logic [15:0] data_out,
  input wire logic data_oe_n,
  // Pins towards the block
  output var host_bus_s pins
);
  // Idle pins at time zero
  initial pins = {4'b1110, 16'h0000};
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // One strobe, five clocks low then five high
  task automatic strobe(input logic sel, input logic wr, input logic [15:0] d, output logic [15:0] q);
    pins.cs_n = 1'b0;
    pins.cmd_sel = sel;
    pins.data = d;
    pins.wr_n = !wr;
    pins.rd_n = wr;
    step(5);
    q = data_oe_n ? 16'hxxxx : data_out;
    pins.wr_n = 1'b1;
    pins.rd_n = 1'b1;
    step(5);
  endtask
  // Command then low word, and high word for 32-bit registers only
  task automatic write_reg(input logic [6:0] cmd, input logic [31:0] v);
    logic [15:0] q;
    strobe(1'b1, 1'b1, {8'h00, 1'b1, cmd}, q);
    strobe(1'b0, 1'b1, v[15:0], q);
    if (cmd < WIDE_REG_LIMIT) begin
      strobe(1'b0, 1'b1, v[31:16], q);
    end
    pins.cs_n = 1'b1;
    pins.data = ~pins.data;
  endtask
  task automatic read_reg(input logic [6:0] cmd, output logic [31:0] v);
    logic [15:0] q;
    v = 32'h0000_0000;
    strobe(1'b1, 1'b1, {9'h000, cmd}, q);
    strobe(1'b0, 1'b0, 16'h0000, v[15:0]);
    if (cmd < WIDE_REG_LIMIT) begin
      strobe(1'b0, 1'b0, 16'h0000, v[31:16]);
    end
    pins.cs_n = 1'b1;
    pins.data = ~pins.data;
  endtask
endmodule
`default_nettype wire

//--- tb/host_suspend_wake_control_bench.sv
// Self-checking bench: register table, sleep entry, wake sources, reset.
// Assumes the host model for pin traffic and scaled timing counts.
`timescale 1ns/10ps
`default_nettype none
module host_suspend_wake_control_bench
  import suspend_wake_pkg::*;
;
  localparam int STOP_N = 20;
  localparam int UP_N = 8;
  localparam int LOW_N = 12;
  logic core_clk;
  logic rst_n;
  logic wake_request_in;
  logic bus_resume_in;
  host_bus_s pins;
  logic [15:0] data_out;
  logic data_oe_n, suspend_out, int_clock_run, pll_osc_on, regulator_power_down, sense_sel;
  logic [31:0] v;
  int n;
  int error_cnt = 0;
  int cmp_count = 0;
  // Command, written value, expected read
  logic [70:0] rows [9] = '{{7'h00, 32'h0000_1234, 32'h0000_0010}, {7'h02, 32'h0000_0005, 32'h0000_0005},
    {7'h0d, 32'h8765_4321, 32'h8765_4321}, {7'h11, 32'h0000_0628, 32'h0000_0628},
    {7'h0e, 32'hffff_ffff, 32'h0000_0000}, {7'h07, 32'h1234_5678, 32'h0000_0000},
    {7'h20, 32'h0000_0400, 32'h0000_0400}, {7'h04, 32'h0000_0008, 32'h0000_0008},
    {7'h05, 32'h0000_0008, 32'h0000_0000}};
  always #5 core_clk = ~core_clk;
  host_suspend_wake_control #(.STOP_COUNT(STOP_N), .WAKE_UP_COUNT(UP_N), .WAKE_LOW_COUNT(LOW_N)) DUT (
    .core_clk(core_clk), .rst_n(rst_n), .cs_n(pins.cs_n), .rd_n(pins.rd_n), .wr_n(pins.wr_n),
    .cmd_sel(pins.cmd_sel), .data_in(pins.data), .data_out(data_out), .data_oe_n(data_oe_n),
    .wake_request_in(wake_request_in), .bus_resume_in(bus_resume_in), .suspend_out(suspend_out),
    .int_clock_run(int_clock_run), .pll_osc_on(pll_osc_on), .regulator_power_down(regulator_power_down),
    .internal_overload_sense_select(sense_sel));
  host_cpu_model cpu (.core_clk(core_clk), .data_out(data_out), .data_oe_n(data_oe_n), .pins(pins));
  // ----------------------------------------
  // Compare, verdict and watchdog
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    $display("Error at %0t: run timed out", $time);
    complete_run();
  end
  // Main sequence
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    wake_request_in = 1'b0;
    bus_resume_in = 1'b0;
    repeat (12) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    cpu.step(3);
    for (int i = 0; i < 9; i++) begin
      cpu.write_reg(rows[i][70:64], rows[i][63:32]);
      cpu.read_reg(rows[i][70:64], v);
      chk(v, rows[i][31:0]);
    end
    chk(sense_sel, 1'b1);
    cpu.write_reg(7'h01, 32'h0000_00c0);
    for (n = 0; n < 20 && suspend_out !== 1'b1; n++) cpu.step(1);
    chk({suspend_out, int_clock_run}, 2'b11);
    cpu.step(STOP_N + 10);
    chk({pll_osc_on, int_clock_run, regulator_power_down}, 3'b001);
    wake_request_in = 1'b1;
    for (n = 0; n < UP_N + 8 && int_clock_run !== 1'b1; n++) cpu.step(1);
    chk(int_clock_run, 1'b1);
    cpu.step(LOW_N * 3);
    chk(int_clock_run, 1'b1);
    wake_request_in = 1'b0;
    cpu.step(LOW_N + 8);
    chk({int_clock_run, suspend_out}, 2'b01);
    cpu.read_reg(7'h24, v);
    chk(v & 32'h0000_0040, 32'h0000_0040);
    chk(int_clock_run, 1'b1);
    cpu.write_reg(7'h01, 32'h0000_0080);
    cpu.step(10);
    chk(suspend_out, 1'b0);
    cpu.read_reg(7'h20, v);
    cpu.write_reg(7'h20, v | 32'h0000_0800);
    cpu.write_reg(7'h04, 32'h0000_0008);
    cpu.write_reg(7'h01, 32'h0000_00c0);
    cpu.step(STOP_N + 20);
    chk({int_clock_run, suspend_out}, 2'b11);
    bus_resume_in = 1'b1;
    cpu.step(6);
    bus_resume_in = 1'b0;
    cpu.read_reg(7'h03, v);
    chk(v, 32'h0000_0008);
    cpu.read_reg(7'h01, v);
    chk({v, suspend_out}, {32'h0000_0040, 1'b1});
    cpu.write_reg(7'h03, 32'h0000_0008);
    cpu.read_reg(7'h03, v);
    chk(v, 32'h0000_0000);
    cpu.write_reg(7'h01, 32'h0000_0000);
    cpu.step(10);
    chk(suspend_out, 1'b0);
    rst_n = 1'b0;
    cpu.step(2);
    chk({sense_sel, data_oe_n}, 2'b01);
    rst_n = 1'b1;
    cpu.step(3);
    cpu.read_reg(7'h20, v);
    chk(v, 32'h0000_0000);
    complete_run();
  end
endmodule
bind host_suspend_wake_control host_suspend_wake_control_monitor #(
  .WAKE_UP_COUNT(WAKE_UP_COUNT), .WAKE_LOW_COUNT(WAKE_LOW_COUNT)) mon (
  .core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
  .wake_request_in(wake_request_in), .data_oe_n(data_oe_n), .suspend_out(suspend_out),
  .int_clock_run(int_clock_run), .pll_osc_on(pll_osc_on), .regulator_power_down(regulator_power_down),
  .internal_overload_sense_select(internal_overload_sense_select));
`default_nettype wire
